// >>> rtl/rli_irq_core.sv
// module: link interrupt mask, raw and masked pending flags
// assumes: event inputs are one-cycle pulses on pclk
//
// What this block does
// - bit 15 lets base ticks through during events; resets to one
// - each source raises its interrupt only while its enable bit is one
// - soft interrupt enable at bit 9, read/write, resets to zero
// - event abort enable at bit 8, read/write, resets to one
// - fine timer enable at bit 7, read/write, resets to zero
// - gross timer enable at bit 6, read/write, resets to zero
// - cipher enable at bit 4, read/write, resets to one
// - event end enable at bit 3, read/write, resets to one
// - wake enable at bit 2, read/write, resets to one
// - receive bit 1 and base tick bit 0 enables, read/write, reset one
// - status bit 9 shows pending soft interrupt, resets zero
// - status bit 8 shows pending event abort interrupt, resets zero
// - status bit 7 shows masked fine timer interrupt, resets zero
// - status bit 6 shows masked gross timer interrupt, resets zero
// - status bit 5 shows fault masked by bit 5 enable, reset zero
// - status bit 4 shows masked cipher interrupt, resets zero
// - status bit 3 shows masked event end interrupt, resets zero
// - status bit 2 shows masked wake interrupt, resets zero
// - status bit 1 shows masked receive interrupt, resets zero
// - status bit 0 shows masked base tick interrupt, resets zero
// - unmasked raw flags readable at the same bit positions
// - writing one to a clear bit drops raw and masked flag; reads zero
// - interrupt outputs are levels held until cleared or until their enable bit is written to zero

`timescale 1ns/1ps

module rli_irq_core (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // source events from the link core
   input  wire logic [8:0]  hw_event,
   input  wire logic        in_event,
   // interrupt outputs
   output logic      [9:0]  irq_status,
   output logic             link_irq
);

   // -------------------------------------------------
   // declarations
   // -------------------------------------------------
   rli_reg_if regs ();

   logic [31:0] mask;
   logic [9:0]  raw;
   logic [9:0]  status;
   logic [9:0]  next_raw;
   logic [9:0]  next_status;
   logic [9:0]  src_set;
   logic [9:0]  ack_clr;
   logic [9:0]  enable;
   logic        soft_set;
   logic        tick_during_event_enable;
   logic        tick_allowed;

   // -------------------------------------------------
   // register bus port
   // -------------------------------------------------
   rli_apb_port u_port (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .regs    (regs.port)
   );

   // -------------------------------------------------
   // enable mask register
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= rli_pkg::MASK_RESET;
      end else if (regs.wr_mask) begin
         mask <= regs.wdata & rli_pkg::MASK_WRITABLE;
      end
   end

   assign enable = mask[rli_pkg::NUM_SRC-1:0];
   assign tick_during_event_enable = mask[rli_pkg::BIT_TDE];

   // hold in the reset and write mask above
   assign regs.mask_word = mask;

   // -------------------------------------------------
   // event inputs
   // -------------------------------------------------
   // no tick is generated inside an event unless allowed
   assign tick_allowed = ~in_event | tick_during_event_enable;

   // soft trigger comes from a register write only
   assign soft_set = regs.wr_trig & regs.wdata[rli_pkg::BIT_SOFT];

   always_comb begin
      src_set = {soft_set, hw_event};
      src_set[rli_pkg::BIT_TICK] = hw_event[rli_pkg::BIT_TICK]
                                   & tick_allowed;
   end

   // clear bits act once, nothing is stored
   assign ack_clr = regs.wr_ack ? regs.wdata[rli_pkg::NUM_SRC-1:0]
                                : rli_pkg::FLAG_RESET;

   // -------------------------------------------------
   // per-source flags
   // -------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < rli_pkg::NUM_SRC; g++) begin : g_src
         // a new event in the clearing cycle wins
         assign next_raw[g] = src_set[g]
                              | (raw[g] & ~ack_clr[g]);
         assign next_status[g] = next_raw[g] & enable[g];
      end
   endgenerate

   // -------------------------------------------------
   // raw pending flags
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw <= rli_pkg::FLAG_RESET;
      end else begin
         raw <= next_raw;
      end
   end

   // -------------------------------------------------
   // masked pending flags
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= rli_pkg::FLAG_RESET;
      end else begin
         // each bit is raw and its enable
         status <= next_status;
      end
   end

   // -------------------------------------------------
   // interrupt line
   // -------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_irq <= 1'b0;
      end else begin
         link_irq <= |next_status;
      end
   end

   assign irq_status = status;

   // -------------------------------------------------
   // read views
   // -------------------------------------------------
   assign regs.stat_word = {22'h000000, status};
   assign regs.raw_word = {22'h000000, raw};

endmodule

// >>> rtl/rli_pkg.sv
// package: register map, field positions and reset values
// assumes: 32-bit apb, registers one aligned word each

package rli_pkg;

   // -------------------------------------------------
   // widths
   // -------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int NUM_SRC = 10;
   localparam int NUM_HW = 9;

   // -------------------------------------------------
   // register byte addresses
   // -------------------------------------------------
   localparam logic [31:0] ADDR_MASK = 32'h4000000C;
   localparam logic [31:0] ADDR_STAT = 32'h40000010;
   localparam logic [31:0] ADDR_RAW = 32'h40000014;
   localparam logic [31:0] ADDR_ACK = 32'h40000018;
   localparam logic [31:0] ADDR_TRIG = 32'h4000001C;

   // -------------------------------------------------
   // source bit positions
   // -------------------------------------------------
   localparam int BIT_TICK = 0;
   localparam int BIT_RX = 1;
   localparam int BIT_WAKE = 2;
   localparam int BIT_EVEND = 3;
   localparam int BIT_CIPHER = 4;
   localparam int BIT_FAULT = 5;
   localparam int BIT_GROSS = 6;
   localparam int BIT_FINE = 7;
   localparam int BIT_ABORT = 8;
   localparam int BIT_SOFT = 9;
   localparam int BIT_TDE = 15;

   // -------------------------------------------------
   // reset values and writable bits
   // -------------------------------------------------
   localparam logic [31:0] MASK_RESET = 32'h0000811F;
   localparam logic [31:0] MASK_WRITABLE = 32'h000083FF;
   localparam logic [9:0] FLAG_RESET = 10'h000;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;

endpackage

// >>> rtl/rli_reg_if.sv
// interface: decoded register access between apb port and core
// assumes: single clock, strobes valid for one cycle

`timescale 1ns/1ps

interface rli_reg_if;
   logic        wr_mask;
   logic        wr_ack;
   logic        wr_trig;
   logic [31:0] wdata;
   logic        sel_mask;
   logic        sel_stat;
   logic        sel_raw;
   logic [31:0] mask_word;
   logic [31:0] stat_word;
   logic [31:0] raw_word;

   modport port (
      output wr_mask, wr_ack, wr_trig, wdata,
      output sel_mask, sel_stat, sel_raw,
      input  mask_word, stat_word, raw_word
   );

   modport core (
      input  wr_mask, wr_ack, wr_trig, wdata,
      input  sel_mask, sel_stat, sel_raw,
      output mask_word, stat_word, raw_word
   );
endinterface

// >>> rtl/rli_apb_port.sv
// module: apb slave, address decode and read data register
// assumes: apb master per protocol, pclk domain only

`timescale 1ns/1ps

module rli_apb_port (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // decoded access
   rli_reg_if.port          regs
);

   logic hit_mask;
   logic hit_stat;
   logic hit_raw;
   logic hit_ack;
   logic hit_trig;
   logic hit_any;
   logic setup;
   logic access;
   logic err_q;

   // -------------------------------------------------
   // decode
   // -------------------------------------------------
   assign hit_mask = (paddr == rli_pkg::ADDR_MASK);
   assign hit_stat = (paddr == rli_pkg::ADDR_STAT);
   assign hit_raw = (paddr == rli_pkg::ADDR_RAW);
   assign hit_ack = (paddr == rli_pkg::ADDR_ACK);
   assign hit_trig = (paddr == rli_pkg::ADDR_TRIG);
   assign hit_any = hit_mask | hit_stat | hit_raw | hit_ack | hit_trig;
   assign setup = psel & ~penable;
   assign access = psel & penable;

   assign regs.sel_mask = hit_mask;
   assign regs.sel_stat = hit_stat;
   assign regs.sel_raw = hit_raw;
   assign regs.wdata = pwdata;
   assign regs.wr_mask = access & pwrite & hit_mask & ~err_q;
   assign regs.wr_ack = access & pwrite & hit_ack & ~err_q;
   assign regs.wr_trig = access & pwrite & hit_trig & ~err_q;

   // -------------------------------------------------
   // answer: one wait-free access after setup
   // -------------------------------------------------
   assign pready = access;
   assign pslverr = access & err_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (setup) begin
         err_q <= ~hit_any;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= rli_pkg::ZERO_WORD;
      end else if (setup) begin
         if (pwrite || !hit_any) begin
            prdata <= rli_pkg::ZERO_WORD;
         end else if (hit_mask) begin
            prdata <= regs.mask_word;
         end else if (hit_stat) begin
            prdata <= regs.stat_word;
         end else if (hit_raw) begin
            prdata <= regs.raw_word;
         end else begin
            prdata <= rli_pkg::ZERO_WORD;
         end
      end
   end

endmodule

// >>> dv/rli_irq_properties.sv
// checker: port relations of the link interrupt core
// assumes: bound to rli_irq_core, one pclk domain

`timescale 1ns/1ps

module rli_irq_properties (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // link side
   input wire logic [8:0]  hw_event,
   input wire logic        in_event,
   input wire logic [9:0]  irq_status,
   input wire logic        link_irq
);
   // ----------------------------------------
   // shadow of the enable register
   // ----------------------------------------
   logic        wr;
   logic        rd;
   logic [31:0] mask_q;
   logic [9:0]  gate;
   logic [9:0]  ev;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign gate = {mask_q[9:1], mask_q[0] && (!in_event || mask_q[15])};
   assign ev = {wr && paddr == rli_pkg::ADDR_TRIG && pwdata[9], hw_event};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= rli_pkg::MASK_RESET;
      end else if (wr && paddr == rli_pkg::ADDR_MASK) begin
         mask_q <= pwdata & rli_pkg::MASK_WRITABLE;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_line_is_or: assert property (
      link_irq == (|irq_status)) else $error("line not or of flags");
   a_event_sets_flag: assert property (
      !(wr && paddr == rli_pkg::ADDR_MASK)
      |=> (irq_status & $past(ev & gate)) == $past(ev & gate))
      else $error("enabled event lost");
   a_disabled_low: assert property (
      (irq_status & ~(mask_q[9:0] | $past(mask_q[9:0]))) == 10'h000)
      else $error("flag shown while disabled");
   a_tick_dropped: assert property (
      hw_event[0] && in_event && !mask_q[15] && mask_q[0] && !wr
      && $stable(mask_q) && !irq_status[0] |=> !irq_status[0])
      else $error("tick raised during event");
   a_flag_holds: assert property (
      !wr && !$past(wr)
      |=> (irq_status & $past(irq_status)) == $past(irq_status))
      else $error("flag fell without clear");
   a_clear_drops: assert property (
      wr && paddr == rli_pkg::ADDR_ACK
      |=> (irq_status & $past(pwdata[9:0] & ~ev)) == 10'h000)
      else $error("clear did not drop flag");
   a_mask_readback: assert property (
      rd && paddr == rli_pkg::ADDR_MASK |-> prdata == mask_q)
      else $error("enable readback wrong");
   a_status_read: assert property (
      rd && paddr == rli_pkg::ADDR_STAT
      |-> prdata == {22'h000000, $past(irq_status)})
      else $error("status readback wrong");
   a_clear_reads_zero: assert property (
      rd && paddr == rli_pkg::ADDR_ACK |-> prdata == rli_pkg::ZERO_WORD)
      else $error("clear register not zero");
endmodule

bind rli_irq_core rli_irq_properties u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .hw_event(hw_event), .in_event(in_event), .irq_status(irq_status),
   .link_irq(link_irq)
);

// >>> dv/tb_top.sv
// testbench: register and flag sequences of the link interrupt core
// assumes: rli_pkg and the checker are compiled first

`timescale 1ns/1ps

module tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [8:0]  hw_event;
   logic        in_event;
   logic [9:0]  irq_status;
   logic        link_irq;
   logic [31:0] rdat;
   logic        rerr;
   int          err_total;
   int          samples_checked;
   int          i;

   rli_irq_core dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hw_event(hw_event),
      .in_event(in_event), .irq_status(irq_status), .link_irq(link_irq)
   );

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(rdat, exp);
   endtask

   task automatic fire(input logic [8:0] e);
      @(posedge pclk);
      hw_event <= e;
      @(posedge pclk);
      hw_event <= 9'h000;
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_total++;
      final_report;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      hw_event = 9'h000;
      in_event = 1'b0;
      err_total = 0;
      samples_checked = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(rli_pkg::ADDR_MASK, 32'h0000811F);
      rd_chk(rli_pkg::ADDR_STAT, 32'h00000000);
      rd_chk(rli_pkg::ADDR_RAW, 32'h00000000);
      fire(9'h1FF);
      rd_chk(rli_pkg::ADDR_STAT, 32'h0000011F);
      check({31'h0, link_irq}, 32'h00000001);
      apb(1'b1, rli_pkg::ADDR_MASK, 32'hFFFFFFFF);
      rd_chk(rli_pkg::ADDR_MASK, 32'h000083FF);
      apb(1'b1, rli_pkg::ADDR_STAT, 32'h00000000);
      rd_chk(rli_pkg::ADDR_STAT, 32'h000001FF);
      apb(1'b1, rli_pkg::ADDR_ACK, 32'h000003FF);
      rd_chk(rli_pkg::ADDR_RAW, 32'h00000000);
      check({31'h0, link_irq}, 32'h00000000);
      rd_chk(rli_pkg::ADDR_ACK, 32'h00000000);
      for (i = 0; i < 10; i++) begin
         apb(1'b1, rli_pkg::ADDR_MASK, 32'h00000001 << i);
         fire(9'h1FF);
         apb(1'b1, rli_pkg::ADDR_TRIG, 32'h00000200);
         rd_chk(rli_pkg::ADDR_STAT, 32'h00000001 << i);
         rd_chk(rli_pkg::ADDR_RAW, 32'h000003FF);
         apb(1'b1, rli_pkg::ADDR_ACK, 32'h000003FF);
      end
      apb(1'b1, rli_pkg::ADDR_MASK, 32'h00000001);
      in_event <= 1'b1;
      fire(9'h001);
      rd_chk(rli_pkg::ADDR_RAW, 32'h00000000);
      apb(1'b1, rli_pkg::ADDR_MASK, 32'h00008001);
      fire(9'h001);
      rd_chk(rli_pkg::ADDR_STAT, 32'h00000001);
      in_event <= 1'b0;
      apb(1'b0, 32'h40000020, 32'h00000000);
      check({rdat[31:1], rerr}, 32'h00000001);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(rli_pkg::ADDR_STAT, 32'h00000000);
      rd_chk(rli_pkg::ADDR_MASK, 32'h0000811F);
      check({31'h0, rerr}, 32'h00000000);
      final_report;
   end
endmodule
